// ===== src/pxb_crossbar.v
// What this block does
// - Analog pin: no pull-up, driver or receiver
// - Input-mode bit 1 digital, 0 analog
// - All pins are digital inputs after reset
// - Output-mode bit picks open drain/push-pull, except on two-wire bus pins
// - Two-wire bus pins always drive open drain
// - Pull-up disable 0 pulls up open-drain pins
// - Pull-up off on pins driving 0
// - Global enable bit 1 enables crossbar
// - Disabled crossbar leaves ports 0-3 pins as plain inputs
// - Ports 0-3 drivers off while crossbar disabled
// - Port 4 always general purpose
// - Skip bit 1 makes crossbar pass pin, except first serial port pins 4,5
// - Lowest free unskipped pin, fixed priority order
// - First serial port fixed at port 0 pins 4,5
// - Two-wire and serial ports assigned as pairs
`timescale 1ns/10ps
`include "pxb_map.vh"

module pxb_crossbar #(
  parameter XB_PINS  = `PXB_XB_PINS,
  parameter ALL_PINS = `PXB_ALL_PINS,
  parameter NPER     = `PXB_NUM_PERIPH,
  parameter IDX_W    = `PXB_IDX_W
) (
  input  wire                   core_clk,
  input  wire                   arst_n,
  input  wire [ALL_PINS-1:0]    port_input_mode,
  input  wire [ALL_PINS-1:0]    port_output_mode,
  input  wire [XB_PINS-1:0]     port_skip_mask,
  input  wire [ALL_PINS-1:0]    port_latch,
  input  wire [7:0]             crossbar_route_a,
  input  wire [7:0]             crossbar_route_b,
  input  wire [1:0]             crossbar_route_c,
  input  wire                   spi_nss_pinned,
  input  wire [NPER-1:0]        periph_out,
  input  wire [NPER-1:0]        periph_drive,
  output reg  [NPER-1:0]        periph_in,
  input  wire [ALL_PINS-1:0]    pad_in,
  output wire [ALL_PINS-1:0]    pad_out,
  output wire [ALL_PINS-1:0]    pad_oe_n,
  output wire [ALL_PINS-1:0]    pad_pullup_en,
  output wire [XB_PINS-1:0]     pin_assigned,
  output wire [XB_PINS*IDX_W-1:0] pin_owner
);

  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  wire       crossbar_global_enable;
  wire       pullup_disable;
  wire [2:0] pca_mode;
  wire [2:0] pca_cnt;

  assign crossbar_global_enable =
    crossbar_route_b[`PXB_B_GLOBAL_EN];
  assign pullup_disable = crossbar_route_b[`PXB_B_PULLUP_DIS];
  assign pca_mode =
    crossbar_route_b[`PXB_B_PCA_MSB:`PXB_B_PCA_LSB];
  // Reserved codes above the channel count route nothing
  assign pca_cnt = (pca_mode <= 3'h5) ? pca_mode : 3'h0;

  // ----------------------------------------------------------------
  // Peripheral selection vector, priority order
  // ----------------------------------------------------------------
  reg [NPER-1:0] sel_w;
  integer        k;

  always @* begin
    sel_w = {NPER{1'b0}};
    // Serial and two-wire ports select both of their pins
    sel_w[`PXB_P_SER_A_TX] = crossbar_route_a[`PXB_A_SER_A];
    sel_w[`PXB_P_SER_A_RX] = crossbar_route_a[`PXB_A_SER_A];
    sel_w[`PXB_P_SPI_CK]   = crossbar_route_a[`PXB_A_SPI];
    sel_w[`PXB_P_SPI_MI]   = crossbar_route_a[`PXB_A_SPI];
    sel_w[`PXB_P_SPI_MO]   = crossbar_route_a[`PXB_A_SPI];
    sel_w[`PXB_P_SPI_SS]   = crossbar_route_a[`PXB_A_SPI]
                           & spi_nss_pinned;
    sel_w[`PXB_P_TW_A_DAT] = crossbar_route_a[`PXB_A_TW_A];
    sel_w[`PXB_P_TW_A_CLK] = crossbar_route_a[`PXB_A_TW_A];
    sel_w[`PXB_P_CMP0]     = crossbar_route_a[`PXB_A_CMP0];
    sel_w[`PXB_P_CMP0_AS]  = crossbar_route_a[`PXB_A_CMP0_AS];
    sel_w[`PXB_P_CMP1]     = crossbar_route_a[`PXB_A_CMP1];
    sel_w[`PXB_P_CMP1_AS]  = crossbar_route_a[`PXB_A_CMP1_AS];
    sel_w[`PXB_P_SYS_CK]   = crossbar_route_a[`PXB_A_SYS_CK];
    for (k = 0; k < `PXB_PCA_MAX; k = k + 1) begin
      sel_w[`PXB_P_PCA_CH0 + k] = (pca_cnt > k[2:0]);
    end
    sel_w[`PXB_P_PCA_EXT]  = crossbar_route_b[`PXB_B_PCA_EXT];
    sel_w[`PXB_P_TMR0]     = crossbar_route_b[`PXB_B_TMR0];
    sel_w[`PXB_P_TMR1]     = crossbar_route_b[`PXB_B_TMR1];
    sel_w[`PXB_P_SER_B_TX] = crossbar_route_c[`PXB_C_SER_B];
    sel_w[`PXB_P_SER_B_RX] = crossbar_route_c[`PXB_C_SER_B];
    sel_w[`PXB_P_TW_B_DAT] = crossbar_route_c[`PXB_C_TW_B];
    sel_w[`PXB_P_TW_B_CLK] = crossbar_route_c[`PXB_C_TW_B];
  end

  // ----------------------------------------------------------------
  // Priority decoder
  // ----------------------------------------------------------------
  reg [XB_PINS-1:0]       taken_w;
  reg [XB_PINS-1:0]       used_d;
  reg [XB_PINS*IDX_W-1:0] owner_d;
  reg                     found_w;
  integer                 p;

  localparam [IDX_W-1:0] SER_TX_OWN = `PXB_P_SER_A_TX;
  localparam [IDX_W-1:0] SER_RX_OWN = `PXB_P_SER_A_RX;
  integer                 i;

  always @* begin
    taken_w = port_skip_mask;
    used_d  = {XB_PINS{1'b0}};
    owner_d = {(XB_PINS*IDX_W){1'b0}};
    found_w = 1'b0;
    // First serial port ignores skip bits and claims its pins first
    if (sel_w[`PXB_P_SER_A_TX]) begin
      taken_w[`PXB_SER_A_TX_PIN] = 1'b1;
      taken_w[`PXB_SER_A_RX_PIN] = 1'b1;
      used_d[`PXB_SER_A_TX_PIN]  = 1'b1;
      used_d[`PXB_SER_A_RX_PIN]  = 1'b1;
      owner_d[`PXB_SER_A_TX_PIN*IDX_W +: IDX_W] = SER_TX_OWN;
      owner_d[`PXB_SER_A_RX_PIN*IDX_W +: IDX_W] = SER_RX_OWN;
    end
    // Pair members are adjacent in priority, so they land together
    for (p = `PXB_P_SPI_CK; p < NPER; p = p + 1) begin
      found_w = 1'b0;
      if (sel_w[p]) begin
        for (i = 0; i < XB_PINS; i = i + 1) begin
          if (!found_w && !taken_w[i]) begin
            taken_w[i] = 1'b1;
            used_d[i]  = 1'b1;
            owner_d[i*IDX_W +: IDX_W] = p[IDX_W-1:0];
            found_w    = 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registered assignment
  // ----------------------------------------------------------------
  reg [XB_PINS-1:0]       used_q;
  reg [XB_PINS*IDX_W-1:0] owner_q;
  reg                     en_q;

  // A full recompute each cycle keeps the map in step with settings
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      used_q  <= {XB_PINS{1'b0}};
      owner_q <= {(XB_PINS*IDX_W){1'b0}};
      en_q    <= 1'b0;
    end else begin
      used_q  <= used_d;
      owner_q <= owner_d;
      en_q    <= crossbar_global_enable;
    end
  end

  assign pin_assigned = used_q & {XB_PINS{en_q}};
  assign pin_owner    = owner_q;

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  wire [ALL_PINS-1:0] pin_in_w;

  genvar g;
  generate
    for (g = 0; g < ALL_PINS; g = g + 1) begin : g_pin
      wire             gate_w;
      wire             psel_w;
      wire             pdrv_w;
      wire             pval_w;
      wire             fod_w;
      wire [IDX_W-1:0] own_w;
      if (g < XB_PINS) begin : g_xb
        assign own_w  = owner_q[g*IDX_W +: IDX_W];
        // Routing only counts while the crossbar is on
        assign psel_w = en_q & used_q[g];
        assign gate_w = en_q;
        assign pdrv_w = periph_drive[own_w];
        assign pval_w = periph_out[own_w];
        assign fod_w  = psel_w & ((own_w == `PXB_P_TW_A_DAT)
                      | (own_w == `PXB_P_TW_A_CLK)
                      | (own_w == `PXB_P_TW_B_DAT)
                      | (own_w == `PXB_P_TW_B_CLK));
      end else begin : g_gp
        assign own_w  = {IDX_W{1'b0}};
        assign psel_w = 1'b0;
        assign gate_w = 1'b1;
        assign pdrv_w = 1'b0;
        assign pval_w = 1'b0;
        assign fod_w  = 1'b0;
      end
      pxb_pin_cell u_cell (
        .core_clk       (core_clk),
        .arst_n         (arst_n),
        .digital_mode   (port_input_mode[g]),
        .push_pull      (port_output_mode[g]),
        .force_od       (fod_w),
        .drv_gate       (gate_w),
        .periph_sel     (psel_w),
        .periph_drive   (pdrv_w),
        .periph_val     (pval_w),
        .latch_val      (port_latch[g]),
        .pullup_disable (pullup_disable),
        .pad_in         (pad_in[g]),
        .pad_out_q      (pad_out[g]),
        .pad_oe_n_q     (pad_oe_n[g]),
        .pullup_en_q    (pad_pullup_en[g]),
        .pin_in_q       (pin_in_w[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Return path from pads to peripherals
  // ----------------------------------------------------------------
  reg [NPER-1:0] back_w;
  integer        j;

  // Unrouted peripheral inputs read 0; one extra cycle of latency
  always @* begin
    back_w = {NPER{1'b0}};
    for (j = 0; j < XB_PINS; j = j + 1) begin
      if (en_q && used_q[j]) begin
        back_w[owner_q[j*IDX_W +: IDX_W]] = pin_in_w[j];
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      periph_in <= {NPER{1'b0}};
    end else begin
      periph_in <= back_w;
    end
  end

endmodule

// ===== inc/pxb_map.vh
`ifndef PXB_MAP_VH
`define PXB_MAP_VH

// ----------------------------------------------------------------
// Pin and peripheral counts
// ----------------------------------------------------------------
`define PXB_XB_PINS      32
`define PXB_ALL_PINS     40
`define PXB_NUM_PERIPH   25
`define PXB_IDX_W        5
`define PXB_PCA_MAX      5

// ----------------------------------------------------------------
// Routing word A bit positions
// ----------------------------------------------------------------
`define PXB_A_SER_A      0
`define PXB_A_SPI        1
`define PXB_A_TW_A       2
`define PXB_A_SYS_CK     3
`define PXB_A_CMP0       4
`define PXB_A_CMP0_AS    5
`define PXB_A_CMP1       6
`define PXB_A_CMP1_AS    7

// ----------------------------------------------------------------
// Routing word B bit positions
// ----------------------------------------------------------------
`define PXB_B_PCA_LSB    0
`define PXB_B_PCA_MSB    2
`define PXB_B_PCA_EXT    3
`define PXB_B_TMR0       4
`define PXB_B_TMR1       5
`define PXB_B_GLOBAL_EN  6
`define PXB_B_PULLUP_DIS 7

// ----------------------------------------------------------------
// Routing word C bit positions
// ----------------------------------------------------------------
`define PXB_C_SER_B      0
`define PXB_C_TW_B       1

// ----------------------------------------------------------------
// Peripheral signal indices, in crossbar priority order
// ----------------------------------------------------------------
`define PXB_P_SER_A_TX   0
`define PXB_P_SER_A_RX   1
`define PXB_P_SPI_CK     2
`define PXB_P_SPI_MI     3
`define PXB_P_SPI_MO     4
`define PXB_P_SPI_SS     5
`define PXB_P_TW_A_DAT   6
`define PXB_P_TW_A_CLK   7
`define PXB_P_CMP0       8
`define PXB_P_CMP0_AS    9
`define PXB_P_CMP1       10
`define PXB_P_CMP1_AS    11
`define PXB_P_SYS_CK     12
`define PXB_P_PCA_CH0    13
`define PXB_P_PCA_EXT    18
`define PXB_P_TMR0       19
`define PXB_P_TMR1       20
`define PXB_P_SER_B_TX   21
`define PXB_P_SER_B_RX   22
`define PXB_P_TW_B_DAT   23
`define PXB_P_TW_B_CLK   24

// ----------------------------------------------------------------
// Fixed pins and reset values
// ----------------------------------------------------------------
`define PXB_SER_A_TX_PIN 4
`define PXB_SER_A_RX_PIN 5
`define PXB_RST_OE_N     1'b1
`define PXB_RST_LOW      1'b0

`endif

// ===== src/pxb_pin_cell.v
`timescale 1ns/10ps
`include "pxb_map.vh"

module pxb_pin_cell (
  input  wire core_clk,
  input  wire arst_n,
  input  wire digital_mode,
  input  wire push_pull,
  input  wire force_od,
  input  wire drv_gate,
  input  wire periph_sel,
  input  wire periph_drive,
  input  wire periph_val,
  input  wire latch_val,
  input  wire pullup_disable,
  input  wire pad_in,
  output reg  pad_out_q,
  output reg  pad_oe_n_q,
  output reg  pullup_en_q,
  output reg  pin_in_q
);

  // ----------------------------------------------------------------
  // Driver and pull-up decision
  // ----------------------------------------------------------------
  wire val_w;
  wire od_w;
  wire drive_on_w;
  wire pull_w;

  // A routed input-only peripheral releases the pin like a latch of 1
  assign val_w = periph_sel ? (periph_drive ? periph_val : 1'b1)
                            : latch_val;
  assign od_w = force_od | ~push_pull;
  // Analog pins and gated ports never drive
  assign drive_on_w = digital_mode & drv_gate
                    & (od_w ? ~val_w : 1'b1);
  // Open drain only drives when low, so driving means driving 0
  assign pull_w = digital_mode & ~pullup_disable & od_w
                & ~drive_on_w;

  // ----------------------------------------------------------------
  // Pad registers
  // ----------------------------------------------------------------
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_out_q   <= `PXB_RST_LOW;
      pad_oe_n_q  <= `PXB_RST_OE_N;
      pullup_en_q <= `PXB_RST_LOW;
      pin_in_q    <= `PXB_RST_LOW;
    end else begin
      pad_out_q   <= od_w ? 1'b0 : val_w;
      pad_oe_n_q  <= ~drive_on_w;
      pullup_en_q <= pull_w;
      pin_in_q    <= digital_mode & pad_in;
    end
  end

endmodule

// ===== testbench/pxb_crossbar_sva.sv
`timescale 1ns/10ps
module pxb_crossbar_sva #(
  parameter XB_PINS  = 32,
  parameter ALL_PINS = 40,
  parameter NPER     = 25,
  parameter IDX_W    = 5
) (
  input wire                     core_clk,
  input wire                     arst_n,
  input wire [ALL_PINS-1:0]      port_input_mode,
  input wire [ALL_PINS-1:0]      port_output_mode,
  input wire [XB_PINS-1:0]       port_skip_mask,
  input wire [ALL_PINS-1:0]      port_latch,
  input wire [7:0]               crossbar_route_a,
  input wire [7:0]               crossbar_route_b,
  input wire [1:0]               crossbar_route_c,
  input wire                     spi_nss_pinned,
  input wire [NPER-1:0]          periph_out,
  input wire [NPER-1:0]          periph_drive,
  input wire [NPER-1:0]          periph_in,
  input wire [ALL_PINS-1:0]      pad_in,
  input wire [ALL_PINS-1:0]      pad_out,
  input wire [ALL_PINS-1:0]      pad_oe_n,
  input wire [ALL_PINS-1:0]      pad_pullup_en,
  input wire [XB_PINS-1:0]       pin_assigned,
  input wire [XB_PINS*IDX_W-1:0] pin_owner
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  wire en = crossbar_route_b[6];
  wire pp32 = port_input_mode[32] & port_output_mode[32];
  off_no_route_a: assert property (!en && !$past(en) |-> !(|pin_assigned))
    else $error("routing while crossbar off");
  // Driver gating lags the enable by two edges
  off_no_drive_a: assert property (!en && !$past(en) && !$past(en, 2)
    |-> &pad_oe_n[XB_PINS-1:0]) else $error("driver on while off");
  analog_off_a: assert property (!port_input_mode[34] &&
    !$past(port_input_mode[34]) |-> pad_oe_n[34] && !pad_pullup_en[34])
    else $error("analog pin not isolated");
  port4_drive_a: assert property (pp32 && $past(pp32) |-> !pad_oe_n[32])
    else $error("port 4 push-pull not driving");
  low_no_pull_a: assert property ((~pad_oe_n & ~pad_out & pad_pullup_en) == 0)
    else $error("pull-up on pin driving low");
  pp_no_pull_a: assert property ((pad_out & pad_pullup_en) == 0)
    else $error("pull-up on push-pull pin");
  tw_open_drain_a: assert property ($past(pin_assigned[0]) &&
    pin_owner[4:0] == 5'h06 && $past(pin_owner[4:0]) == 5'h06 |-> !pad_out[0])
    else $error("two-wire pin driven high");
  ser_fixed_a: assert property ($past(en && crossbar_route_a[0]) |->
    pin_assigned[5:4] == 2'h3 && pin_owner[29:20] == {5'h01, 5'h00})
    else $error("serial pins not fixed");
  tw_pair_a: assert property ($past(en && crossbar_route_a == 8'h04 &&
    crossbar_route_b[5:0] == 6'h00 && crossbar_route_c == 2'h0 &&
    port_skip_mask[1:0] == 2'h0) |-> pin_assigned[1:0] == 2'h3 &&
    pin_owner[9:0] == {5'h07, 5'h06}) else $error("two-wire pair wrong");
  ser_seen_c: cover property ($past(en) && crossbar_route_a[0]);
  tw_low_c: cover property (!pad_oe_n[0] && pin_owner[4:0] == 5'h06);
  analog_c: cover property (!port_input_mode[34]);
endmodule

// ===== testbench/pxb_pad_model.sv
`timescale 1ns/10ps
module pxb_pad_model (
  input  wire        core_clk,
  input  wire [39:0] pad_out,
  input  wire [39:0] pad_oe_n,
  input  wire [39:0] pad_pullup_en,
  output wire [39:0] pad_in
);
  // Floating pad shows the inverse of its last level, so a missing
  // pull-up can never hold a steady high by luck
  logic [39:0] last_q = 40'h0;
  assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & pad_pullup_en)
                | (pad_oe_n & ~pad_pullup_en & ~last_q);
  always @(posedge core_clk) begin
    last_q <= pad_in;
  end
endmodule

// ===== testbench/pxb_crossbar_bench.sv
`timescale 1ns/10ps
module pxb_crossbar_bench;
  logic         core_clk;
  logic         arst_n;
  logic [39:0]  in_mode, out_mode, latch;
  logic [31:0]  skip;
  logic [7:0]   ra, rb;
  logic [1:0]   rc;
  logic         nss;
  logic [24:0]  pout, pdrv;
  wire  [24:0]  pin_ret;
  wire  [39:0]  pad_in, pad_out, pad_oe_n, pad_pu;
  wire  [31:0]  asg;
  wire  [159:0] own;
  int           bad_count = 0;
  int           cmp_count = 0;
  int           cyc = 0;

  pxb_crossbar u_dut (.core_clk(core_clk), .arst_n(arst_n),
    .port_input_mode(in_mode), .port_output_mode(out_mode),
    .port_skip_mask(skip), .port_latch(latch), .crossbar_route_a(ra),
    .crossbar_route_b(rb), .crossbar_route_c(rc), .spi_nss_pinned(nss),
    .periph_out(pout), .periph_drive(pdrv), .periph_in(pin_ret),
    .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_pullup_en(pad_pu), .pin_assigned(asg), .pin_owner(own));
  pxb_pad_model u_pad (.core_clk(core_clk), .pad_out(pad_out),
    .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pu), .pad_in(pad_in));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Run needs about 40 cycles; ceiling leaves wide margin
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      print_verdict;
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task print_verdict;
    if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [159:0] got, input logic [159:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk(pad_oe_n, 40'hFFFFFFFFFF, "not inputs after reset");
    chk(asg, 32'h0, "route while off");
    chk(pad_pu, 40'hFFFFFFFFFF, "open-drain pull-ups");
  endtask
  task t_twowire;
    out_mode[1:0] = 2'h3; // Modes before routes before enable
    ra = 8'h04;
    rb = 8'h40;
    tick(1);
    chk(asg[1:0], 2'h3, "pair late");
    chk(own[9:0], {5'h07, 5'h06}, "pair owners");
    pdrv[7:6] = 2'h3;
    pout[7:6] = 2'h2;
    tick(3);
    chk({pad_oe_n[1:0], pad_out[1:0]}, 4'h8, "pair not open drain");
    chk(pad_pu[1:0], 2'h2, "pull-up on low pin");
    tick(2);
    chk(pin_ret[7:6], 2'h2, "returned levels");
    pdrv = 25'h0;
    ra = 8'h00;
    out_mode[1:0] = 2'h0;
  endtask
  task t_serial_skip;
    skip = 32'h00000031;
    nss = 1'b1;
    out_mode[3] = 1'b1;
    ra = 8'h03;
    pdrv[4:3] = 2'h3;
    pout[4:3] = 2'h3;
    tick(3);
    chk(asg[7:0], 8'h7E, "skipped pin taken");
    chk(own[29:20], {5'h01, 5'h00}, "serial pins moved");
    chk(own[34:5], {5'h05, 5'h01, 5'h00, 5'h04, 5'h03, 5'h02}, "order");
    chk({pad_oe_n[3:2], pad_out[3:2]}, 4'h6, "output mode");
    ra = 8'h00;
    skip = 32'h0;
    pdrv = 25'h0;
    nss = 1'b0;
    out_mode[3] = 1'b0;
  endtask
  task t_pullup_off;
    rb = 8'hC0;
    tick(3);
    chk(pad_pu, 40'h0, "pull-ups not disabled");
    rb = 8'h40;
  endtask
  task t_port4;
    rb = 8'h00;
    in_mode[34] = 1'b0;
    in_mode[9] = 1'b0;
    skip[9] = 1'b1; // Analog pin kept from the crossbar
    out_mode[34:32] = 3'h7;
    out_mode[8] = 1'b1;
    latch[32] = 1'b0;
    latch[8] = 1'b0;
    tick(3);
    chk({pad_oe_n[34:32], pad_out[33:32]}, 5'h12, "port 4");
    chk(pad_pu[34], 1'h0, "analog pull-up");
    chk(pad_oe_n[8], 1'h1, "gated driver on");
    in_mode = 40'hFFFFFFFFFF;
    out_mode = 40'h0;
    latch = 40'hFFFFFFFFFF;
    skip = 32'h0;
  endtask
  task t_disable;
    out_mode[15:8] = 8'hFF;
    latch[15:8] = 8'h00;
    ra = 8'h01;
    rb = 8'h40;
    tick(3);
    chk(asg[5:4], 2'h3, "enable ignored");
    chk(pad_oe_n[15:8], 8'h00, "port output off");
    rb = 8'h00;
    tick(3);
    chk({asg, pad_oe_n[31:0]}, {32'h0, 32'hFFFFFFFF}, "still on");
    ra = 8'h00;
  endtask
  task t_second_ports;
    rb = 8'h47; // Reserved channel code routes nothing
    rc = 2'h3;
    out_mode[3:2] = 2'h3;
    pdrv[24:23] = 2'h3;
    pout[24:23] = 2'h3;
    tick(3);
    chk(asg[7:0], 8'h0F, "second ports placed");
    chk(own[19:0], {5'h18, 5'h17, 5'h16, 5'h15}, "second pairs");
    chk({pad_oe_n[3:2], pad_out[3:2]}, 4'hC, "second bus push-pull");
    rb = 8'h00;
    rc = 2'h0;
    pdrv = 25'h0;
    out_mode[3:2] = 2'h0;
  endtask

  initial begin
    arst_n = 1'b0;
    in_mode = 40'hFFFFFFFFFF;
    out_mode = 40'h0; // Digital inputs: open drain, latch high
    latch = 40'hFFFFFFFFFF;
    skip = 32'h0;
    ra = 8'h00;
    rb = 8'h00;
    rc = 2'h0;
    nss = 1'b0;
    pout = 25'h0;
    pdrv = 25'h0;
    tick(12);
    arst_n = 1'b1;
    tick(3);
    t_reset;
    t_twowire;
    t_serial_skip;
    t_pullup_off;
    t_port4;
    t_disable;
    t_second_ports;
    print_verdict;
  end
endmodule

bind pxb_crossbar pxb_crossbar_sva #(.XB_PINS(XB_PINS),
  .ALL_PINS(ALL_PINS), .NPER(NPER), .IDX_W(IDX_W)) u_sva (
  .core_clk(core_clk), .arst_n(arst_n), .port_input_mode(port_input_mode),
  .port_output_mode(port_output_mode), .port_skip_mask(port_skip_mask),
  .port_latch(port_latch), .crossbar_route_a(crossbar_route_a),
  .crossbar_route_b(crossbar_route_b), .crossbar_route_c(crossbar_route_c),
  .spi_nss_pinned(spi_nss_pinned), .periph_out(periph_out),
  .periph_drive(periph_drive), .periph_in(periph_in), .pad_in(pad_in),
  .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup_en(pad_pullup_en),
  .pin_assigned(pin_assigned), .pin_owner(pin_owner));
